// ==== logic/acfd_pkg.sv ====
// constants and types for the converter configuration decode block
//
// Behaviour
// - reference select zero picks first reference pair
// - reference select one picks shared second pair
// - arrangement bit: eight pseudo or four differential
// - enable mask drives sequencer, full settling each
// - burnout on only with buffer, without chop
// - missing-reference flag only while detecting and converting
`default_nettype none

package acfd_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CFG_W = 24;
   localparam int CH_N = 10;
   localparam int EV_W = 3;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CFG = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_INT_STAT = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_INT_CLR = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_INT_EN = 8'h10;

   typedef enum logic [2:0] {
      IDX_CFG = 3'h0,
      IDX_STATUS = 3'h1,
      IDX_INT_STAT = 3'h2,
      IDX_INT_CLR = 3'h3,
      IDX_INT_EN = 3'h4,
      IDX_NONE = 3'h7
   } acfd_idx_e;

   // configuration field positions
   localparam int CHOP_BIT = 23;
   localparam int REFERENCE_SOURCE_SELECT_BIT = 20;
   localparam int PSEUDO_BIT = 18;
   localparam int MASK_LSB = 8;
   localparam int BURN_BIT = 7;
   localparam int REFERENCE_LOSS_DETECT_ENABLE_BIT = 6;
   localparam int BUF_BIT = 4;
   localparam logic [CFG_W-1:0] CFG_RESERVED_MASK = 24'h68_0020;
   localparam logic [CFG_W-1:0] CFG_RESET = 24'h00_0117;

   // status register fields
   localparam int ST_MISSING_BIT = 0;
   localparam int ST_BUSY_BIT = 1;
   localparam int ST_SEL_LSB = 8;

   // interrupt event bits
   localparam int EV_CONV_DONE = 0;
   localparam int EV_REF_LOST = 1;
   localparam int EV_RSV_WRITE = 2;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam int SYNC_STAGES = 3;
   localparam logic [3:0] SEQ_IDX_RESET = 4'h9;

   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b001,
      SEQ_START = 3'b010,
      SEQ_WAIT = 3'b100
   } acfd_seq_e;

endpackage

`default_nettype wire

// ==== logic/acfd_chan_seq.sv ====
// automatic channel sequencer over the enabled channel mask
`default_nettype none

module acfd_chan_seq import acfd_pkg::*; (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // control
   input wire logic [CH_N-1:0] chan_mask,
   input wire logic conv_done,
   // converter side
   output logic [CH_N-1:0] channel_sel,
   output logic conv_start,
   output logic busy
);

   acfd_seq_e state_reg, state_next;
   logic [3:0] idx_reg, idx_next;
   logic [CH_N-1:0] channel_sel_next;
   logic conv_start_next;
   logic busy_next;

   // circular search for the next enabled channel after cur
   function automatic logic [3:0] next_chan(input logic [CH_N-1:0] mask, input logic [3:0] cur);
      logic [3:0] res;
      logic found;
      int j;
      res = cur;
      found = 1'b0;
      for (int i = 1; i <= CH_N; i++) begin
         j = (int'(cur) + i) % CH_N;
         if (!found && mask[j]) begin
            res = 4'(j);
            found = 1'b1;
         end
      end
      return res;
   endfunction

   always_comb begin
      state_next = state_reg;
      idx_next = idx_reg;
      case (state_reg)
         SEQ_IDLE: begin
            if (|chan_mask) begin
               idx_next = next_chan(chan_mask, idx_reg);
               state_next = SEQ_START;
            end
         end
         SEQ_START: state_next = SEQ_WAIT;
         SEQ_WAIT: begin
            // move on only after the full settled conversion
            if (conv_done) begin
               if (|chan_mask) begin
                  idx_next = next_chan(chan_mask, idx_reg);
                  state_next = SEQ_START;
               end else begin
                  state_next = SEQ_IDLE;
               end
            end
         end
         default: state_next = SEQ_IDLE;
      endcase
      conv_start_next = (state_next == SEQ_START);
      busy_next = (state_next != SEQ_IDLE);
      for (int k = 0; k < CH_N; k++) begin
         channel_sel_next[k] = busy_next && (idx_next == 4'(k));
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= SEQ_IDLE;
         idx_reg <= SEQ_IDX_RESET;
         channel_sel <= '0;
         conv_start <= 1'b0;
         busy <= 1'b0;
      end else begin
         state_reg <= state_next;
         idx_reg <= idx_next;
         channel_sel <= channel_sel_next;
         conv_start <= conv_start_next;
         busy <= busy_next;
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   sequence s_done_more;
      state_reg == SEQ_WAIT && conv_done && |chan_mask;
   endsequence

   a_seq_onehot_sel: assert property ($onehot0(channel_sel))
      else $error("channel select not one-hot");
   a_seq_next_start: assert property (s_done_more |=> conv_start && busy)
      else $error("sequencer did not start next channel");
   a_seq_settle_wait: assert property (
      state_reg == SEQ_WAIT && !conv_done |=> !conv_start)
      else $error("conversion started before settling finished");
   a_seq_mask_pick: assert property (
      conv_start |-> |(channel_sel & $past(chan_mask)))
      else $error("started channel not enabled in mask");

endmodule // acfd_chan_seq

`default_nettype wire

// ==== logic/acfd_top.sv ====
// configuration field decode with axi4-lite registers and interrupt
`default_nettype none

module acfd_top import acfd_pkg::*; (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // axi4-lite write
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // converter pins
   input wire logic conv_done_pin,
   input wire logic ref_low_pin,
   // converter controls
   output logic ref_second_select,
   output logic pseudo_mode,
   output logic burnout_enable,
   output logic reference_missing_flag,
   output logic [CH_N-1:0] channel_sel,
   output logic conv_start,
   // interrupt
   output logic irq
);

   function automatic acfd_idx_e reg_index(input logic [ADDR_W-1:0] addr);
      if (addr == OFF_CFG) begin
         return IDX_CFG;
      end else if (addr == OFF_STATUS) begin
         return IDX_STATUS;
      end else if (addr == OFF_INT_STAT) begin
         return IDX_INT_STAT;
      end else if (addr == OFF_INT_CLR) begin
         return IDX_INT_CLR;
      end else if (addr == OFF_INT_EN) begin
         return IDX_INT_EN;
      end else begin
         return IDX_NONE;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: a change counts once stages two and three agree
   logic [1:0] pin_in;
   logic [SYNC_STAGES-1:0] sync_reg [2];
   logic [1:0] filt_reg, filt_next;
   logic done_d_reg, done_d_next;
   assign pin_in = {ref_low_pin, conv_done_pin};

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_sync
         always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
               sync_reg[g] <= '0;
            end else begin
               sync_reg[g] <= {sync_reg[g][SYNC_STAGES-2:0], pin_in[g]};
            end
         end
         always_comb begin
            filt_next[g] = filt_reg[g];
            if (sync_reg[g][1] == sync_reg[g][2]) begin
               filt_next[g] = sync_reg[g][2];
            end
         end
      end
   endgenerate

   logic conv_done_pulse;
   assign done_d_next = filt_reg[0];
   assign conv_done_pulse = filt_reg[0] && !done_d_reg;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         filt_reg <= '0;
         done_d_reg <= 1'b0;
      end else begin
         filt_reg <= filt_next;
         done_d_reg <= done_d_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus slave and register file
   logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
   logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
   logic [DATA_W-1:0] w_data_reg, w_data_next;
   logic [3:0] w_strb_reg, w_strb_next;
   logic awready_next, wready_next, bvalid_next, arready_next, rvalid_next;
   logic [1:0] bresp_next, rresp_next;
   logic [DATA_W-1:0] rdata_next, rd_word;
   logic [CFG_W-1:0] cfg_reg, cfg_next;
   logic [EV_W-1:0] int_stat_reg, int_stat_next, int_en_reg, int_en_next, events, clr_bits;
   logic irq_next, wr_go, missing_next;
   acfd_idx_e wr_idx, rd_idx;
   logic seq_busy;

   assign wr_idx = reg_index(aw_addr_reg);
   assign rd_idx = reg_index(s_axi_araddr);

   always_comb begin
      rd_word = '0;
      if (rd_idx == IDX_CFG) begin
         rd_word[CFG_W-1:0] = cfg_reg;
      end else if (rd_idx == IDX_STATUS) begin
         rd_word[ST_MISSING_BIT] = reference_missing_flag;
         rd_word[ST_BUSY_BIT] = seq_busy;
         rd_word[ST_SEL_LSB +: CH_N] = channel_sel;
      end else if (rd_idx == IDX_INT_STAT) begin
         rd_word[EV_W-1:0] = int_stat_reg;
      end else if (rd_idx == IDX_INT_EN) begin
         rd_word[EV_W-1:0] = int_en_reg;
      end
   end

   always_comb begin
      aw_held_next = aw_held_reg;
      aw_addr_next = aw_addr_reg;
      w_held_next = w_held_reg;
      w_data_next = w_data_reg;
      w_strb_next = w_strb_reg;
      bvalid_next = s_axi_bvalid;
      bresp_next = s_axi_bresp;
      rvalid_next = s_axi_rvalid;
      rdata_next = s_axi_rdata;
      rresp_next = s_axi_rresp;
      wr_go = 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_held_next = 1'b1;
         aw_addr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_held_next = 1'b1;
         w_data_next = s_axi_wdata;
         w_strb_next = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
      // both halves in hand: commit and answer
      if (aw_held_reg && w_held_reg && !s_axi_bvalid) begin
         wr_go = 1'b1;
         aw_held_next = 1'b0;
         w_held_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = (wr_idx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      awready_next = !aw_held_next && !bvalid_next;
      wready_next = !w_held_next && !bvalid_next;
      if (s_axi_rvalid && s_axi_rready) begin
         rvalid_next = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_next = 1'b1;
         rdata_next = rd_word;
         rresp_next = (rd_idx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      arready_next = !rvalid_next;
   end

   always_comb begin
      cfg_next = cfg_reg;
      if (wr_go && wr_idx == IDX_CFG) begin
         for (int b = 0; b < 3; b++) begin
            if (w_strb_reg[b]) begin
               cfg_next[8*b +: 8] = w_data_reg[8*b +: 8];
            end
         end
      end
      // reserved bits are kept as written so software can see its mistake
      events = '0;
      events[EV_CONV_DONE] = conv_done_pulse && seq_busy;
      events[EV_RSV_WRITE] = wr_go && wr_idx == IDX_CFG && |(cfg_next & CFG_RESERVED_MASK);
      events[EV_REF_LOST] = missing_next && !reference_missing_flag;
      clr_bits = (wr_go && wr_idx == IDX_INT_CLR && w_strb_reg[0]) ? w_data_reg[EV_W-1:0] : '0;
      int_stat_next = (int_stat_reg & ~clr_bits) | events;
      int_en_next = int_en_reg;
      if (wr_go && wr_idx == IDX_INT_EN && w_strb_reg[0]) begin
         int_en_next = w_data_reg[EV_W-1:0];
      end
      irq_next = |(int_stat_next & int_en_next);
   end

   ////////////////////////////////////////////////////////////////////////////
   // field decode to converter controls
   logic ref_sel_next, pseudo_next, burn_next;

   always_comb begin
      ref_sel_next = cfg_reg[REFERENCE_SOURCE_SELECT_BIT];
      pseudo_next = cfg_reg[PSEUDO_BIT];
      // sources would load an unbuffered or chopped input
      burn_next = cfg_reg[BURN_BIT] && cfg_reg[BUF_BIT] && !cfg_reg[CHOP_BIT];
      missing_next = cfg_reg[REFERENCE_LOSS_DETECT_ENABLE_BIT] && seq_busy && filt_reg[1];
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_held_reg <= 1'b0;
         w_data_reg <= '0;
         w_strb_reg <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
         cfg_reg <= CFG_RESET;
         int_stat_reg <= '0;
         int_en_reg <= '0;
         irq <= 1'b0;
         ref_second_select <= 1'b0;
         pseudo_mode <= 1'b0;
         burnout_enable <= 1'b0;
         reference_missing_flag <= 1'b0;
      end else begin
         aw_held_reg <= aw_held_next;
         aw_addr_reg <= aw_addr_next;
         w_held_reg <= w_held_next;
         w_data_reg <= w_data_next;
         w_strb_reg <= w_strb_next;
         s_axi_awready <= awready_next;
         s_axi_wready <= wready_next;
         s_axi_bvalid <= bvalid_next;
         s_axi_bresp <= bresp_next;
         s_axi_arready <= arready_next;
         s_axi_rvalid <= rvalid_next;
         s_axi_rdata <= rdata_next;
         s_axi_rresp <= rresp_next;
         cfg_reg <= cfg_next;
         int_stat_reg <= int_stat_next;
         int_en_reg <= int_en_next;
         irq <= irq_next;
         ref_second_select <= ref_sel_next;
         pseudo_mode <= pseudo_next;
         burnout_enable <= burn_next;
         reference_missing_flag <= missing_next;
      end
   end

   acfd_chan_seq u_seq (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .chan_mask(cfg_reg[MASK_LSB +: CH_N]),
      .conv_done(conv_done_pulse),
      .channel_sel(channel_sel),
      .conv_start(conv_start),
      .busy(seq_busy)
   );

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   a_ref_first_pair: assert property (!cfg_reg[REFERENCE_SOURCE_SELECT_BIT] |=> !ref_second_select)
      else $error("first reference pair not selected");
   a_ref_second_pair: assert property (cfg_reg[REFERENCE_SOURCE_SELECT_BIT] |=> ref_second_select)
      else $error("second reference pair not selected");
   a_input_arrangement: assert property (pseudo_mode == $past(cfg_reg[PSEUDO_BIT]))
      else $error("input arrangement does not follow configuration");
   a_burnout_gate: assert property (
      burnout_enable |-> $past(cfg_reg[BUF_BIT] && !cfg_reg[CHOP_BIT] && cfg_reg[BURN_BIT]))
      else $error("burnout sources on without buffer or with chop");
   a_burnout_on: assert property (
      cfg_reg[BURN_BIT] && cfg_reg[BUF_BIT] && !cfg_reg[CHOP_BIT] |=> burnout_enable)
      else $error("burnout sources not enabled");
   a_ref_missing_cause: assert property (
      reference_missing_flag |-> $past(cfg_reg[REFERENCE_LOSS_DETECT_ENABLE_BIT] && seq_busy && filt_reg[1]))
      else $error("missing reference flagged without cause");
   a_ref_missing_set: assert property (
      cfg_reg[REFERENCE_LOSS_DETECT_ENABLE_BIT] && seq_busy && filt_reg[1] |=> reference_missing_flag)
      else $error("missing reference not flagged");
   a_status_sticky: assert property (
      int_stat_reg[EV_CONV_DONE] && !clr_bits[EV_CONV_DONE] |=> int_stat_reg[EV_CONV_DONE])
      else $error("sticky status bit lost");

endmodule // acfd_top

`default_nettype wire

// ==== verification/acfd_conv_model.sv ====
// behavioural converter front end answering start pulses with done edges
`default_nettype none

module acfd_conv_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // from block
   input wire logic conv_start,
   // scenario controls
   input wire logic [7:0] settle_cycles,
   input wire logic ref_open,
   // to block
   output logic conv_done_pin,
   output logic ref_low_pin
);
   logic [7:0] wait_cnt;
   logic [3:0] pulse_cnt;

   ////////////////////////////////////////////////////////////////////////////////
   // done pulse long enough for the block's pin filter
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         wait_cnt <= 8'h00;
         pulse_cnt <= 4'h0;
      end else begin
         if (conv_start) begin
            wait_cnt <= settle_cycles;
         end else if (wait_cnt != 8'h00) begin
            wait_cnt <= wait_cnt - 8'h01;
         end
         if (wait_cnt == 8'h01 && !conv_start) begin
            pulse_cnt <= 4'h8;
         end else if (pulse_cnt != 4'h0) begin
            pulse_cnt <= pulse_cnt - 4'h1;
         end
      end
   end

   assign conv_done_pin = (pulse_cnt != 4'h0);
   assign ref_low_pin = ref_open;
endmodule // acfd_conv_model

`default_nettype wire

// ==== verification/adc_config_field_decode_tb.sv ====
// self-checking bench for the configuration decode block
`default_nettype none

module adc_config_field_decode_tb import acfd_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;

   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, settle_cycles = 8'h14;
   logic [31:0] wdata = 32'h0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, ref_open = 1'b0;
   logic [1:0] bresp, rresp, resp;
   logic conv_done_pin, ref_low_pin, ref_second_select, pseudo_mode, burnout_enable;
   logic reference_missing_flag, conv_start, irq;
   logic [CH_N-1:0] channel_sel, ch;
   logic [31:0] rd_val;
   int fails = 0, n_checks = 0, cyc = 0;

   always #2.5 sys_clk = ~sys_clk;

   acfd_top dut (.sys_clk(sys_clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .conv_done_pin(conv_done_pin), .ref_low_pin(ref_low_pin),
      .ref_second_select(ref_second_select), .pseudo_mode(pseudo_mode),
      .burnout_enable(burnout_enable), .reference_missing_flag(reference_missing_flag),
      .channel_sel(channel_sel), .conv_start(conv_start), .irq(irq));

   acfd_conv_model conv (.sys_clk(sys_clk), .reset_n(reset_n), .conv_start(conv_start),
      .settle_cycles(settle_cycles), .ref_open(ref_open), .conv_done_pin(conv_done_pin),
      .ref_low_pin(ref_low_pin));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic results();
      if (fails == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // handshakes judged at the falling edge, where both sides have settled
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ah, wh, bh;
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge sys_clk);
         ah = awvalid && awready;
         wh = wvalid && wready;
         bh = bvalid;
         resp = bresp;
         @(posedge sys_clk);
         if (ah) awvalid <= 1'b0;
         if (wh) wvalid <= 1'b0;
      end while (!bh);
      bready <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask

   task automatic rd(input logic [7:0] a);
      logic ah, rh;
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge sys_clk);
         ah = arvalid && arready;
         rh = rvalid;
         rd_val = rdata;
         resp = rresp;
         @(posedge sys_clk);
         if (ah) arvalid <= 1'b0;
      end while (!rh);
      rready <= 1'b0;
   endtask

   task automatic next_start();
      do @(negedge sys_clk); while (!conv_start);
      ch = channel_sel;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reference_source_select();
      wr(OFF_CFG, 32'h0011_0117);
      chk("ref second", ref_second_select, 1);
      wr(OFF_CFG, 32'h0000_0117);
      chk("ref first", ref_second_select, 0);
      wr(OFF_CFG, 32'h0004_0117);
      chk("pseudo on", pseudo_mode, 1);
      wr(OFF_CFG, 32'h0000_0117);
      chk("pseudo off", pseudo_mode, 0);
   endtask

   task automatic t_burnout();
      wr(OFF_CFG, 32'h0000_0197);
      chk("burn buf nochop", burnout_enable, 1);
      wr(OFF_CFG, 32'h0080_0197);
      chk("burn chop", burnout_enable, 0);
      wr(OFF_CFG, 32'h0000_0197);
      chk("burn back on", burnout_enable, 1);
      wr(OFF_CFG, 32'h0000_0187);
      chk("burn nobuf", burnout_enable, 0);
      wr(OFF_CFG, 32'h0000_0197);
      chk("burn on again", burnout_enable, 1);
      wr(OFF_CFG, 32'h0000_0117);
      chk("burn cleared", burnout_enable, 0);
   endtask

   // ch0, ch2 and temperature: order must wrap ch0, ch2, temp
   task automatic t_sequence();
      logic [CH_N-1:0] exp_ch;
      wr(OFF_CFG, 32'h0001_0517);
      next_start();
      exp_ch = ch;
      repeat (4) begin
         exp_ch = (exp_ch == 10'h001) ? 10'h004 : (exp_ch == 10'h004) ? 10'h100 : 10'h001;
         next_start();
         chk("sequence channel", ch, exp_ch);
      end
      @(negedge sys_clk);
      chk("start one cycle", conv_start, 0);
   endtask

   task automatic t_reference_loss_detect_enable();
      wr(OFF_INT_EN, 32'h0000_0002);
      wr(OFF_CFG, 32'h0000_0157);
      ref_open <= 1'b1;
      repeat (12) @(posedge sys_clk);
      chk("missing flag", reference_missing_flag, 1);
      rd(OFF_STATUS);
      chk("status missing", rd_val[ST_MISSING_BIT], 1);
      chk("status busy", rd_val[ST_BUSY_BIT], 1);
      chk("irq raised", irq, 1);
      wr(OFF_INT_EN, 32'h0000_0000);
      chk("irq masked", irq, 0);
      ref_open <= 1'b0;
      wr(OFF_CFG, 32'h0000_0057);
      repeat (80) @(posedge sys_clk);
      ref_open <= 1'b1;
      repeat (12) @(posedge sys_clk);
      chk("idle no flag", reference_missing_flag, 0);
      chk("idle channel", channel_sel, 10'h000);
   endtask

   task automatic t_regs();
      wr(OFF_CFG, 32'h0008_0117);
      rd(OFF_INT_STAT);
      chk("reserved event", rd_val[EV_RSV_WRITE], 1);
      wr(OFF_INT_CLR, 32'h0000_0007);
      chk("mapped write", resp, RESP_OKAY);
      rd(OFF_INT_STAT);
      chk("int cleared", rd_val, 32'h0000_0000);
      rd(8'h20);
      chk("unmapped read", {rd_val[3:0], 2'h0, resp}, {4'h0, 2'h0, RESP_SLVERR});
      wr(8'h24, 32'hFFFF_FFFF);
      chk("unmapped write", resp, RESP_SLVERR);
   endtask

   // mid-run reset must restore the configuration and drop sticky events
   task automatic t_reset();
      reset_n <= 1'b0;
      repeat (5) @(posedge sys_clk);
      reset_n <= 1'b1;
      rd(OFF_CFG);
      chk("config after reset", rd_val, {8'h00, CFG_RESET});
      rd(OFF_INT_STAT);
      chk("int after reset", rd_val, 32'h0000_0000);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         results();
      end
   end

   initial begin
      repeat (5) @(posedge sys_clk);
      reset_n <= 1'b1;
      rd(OFF_CFG);
      chk("config reset", rd_val, {8'h00, CFG_RESET});
      chk("config resp", resp, RESP_OKAY);
      t_reference_source_select();
      t_burnout();
      t_sequence();
      t_reference_loss_detect_enable();
      t_regs();
      t_reset();
      results();
   end
endmodule // adc_config_field_decode_tb

`default_nettype wire
